// ---- ccu_defines.vh ----
`ifndef CCU_DEFINES_VH
`define CCU_DEFINES_VH

// ****************************************
// Register offsets
// ****************************************
`define CCU_ADDR_U1_LOW   8'h15
`define CCU_ADDR_U1_HIGH  8'h16
`define CCU_ADDR_U1_CTRL  8'h17
`define CCU_ADDR_U2_LOW   8'h1b
`define CCU_ADDR_U2_HIGH  8'h1c
`define CCU_ADDR_U2_CTRL  8'h1d

// ****************************************
// Control register layout
// ****************************************
`define CCU_CTRL_RESET    6'h00
`define CCU_CTRL_W        6
`define CCU_MODE_MSB      3
`define CCU_MODE_LSB      0
`define CCU_DUTY_MSB      5
`define CCU_DUTY_LSB      4
`define CCU_RD_ZERO       8'h00

// ****************************************
// Mode select codes
// ****************************************
`define CCU_MODE_OFF      4'h0
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_4    4'h6
`define CCU_MODE_CAP_16   4'h7
`define CCU_MODE_CMP_SET  4'h8
`define CCU_MODE_CMP_CLR  4'h9
`define CCU_MODE_CMP_SW   4'ha
`define CCU_MODE_CMP_SPEC 4'hb

// ****************************************
// Prescale terminal counts
// ****************************************
`define CCU_PS_LAST4      4'h3
`define CCU_PS_MASK4      4'h3
`define CCU_PS_LAST16     4'hf
`define CCU_PS_RESET      4'h0
`define CCU_VAL_RESET     16'h0000

`endif

// ---- ccu_top.v ----
// Overview of operation
// R01: 16-bit value accessed as two bytes
// R02: Both units identical except special trigger
// R03: Mode zero disables, resets internal state
// R04: Modes 0100/0101 capture falling/rising edges
// R05: Modes 0110/0111 capture every 4th/16th rise
// R06: Capture copies full 16-bit timer count
// R07: Capture sets event flag; software clears
// R08: New capture overwrites, no overrun flag
// R09: Edge detector watches pin regardless of direction
// R10: Mode 1000 drives output high, sets flag
// R11: Mode 1001 drives output low, sets flag
// R12: Mode 1010 only sets flag on match
// R13: Mode 1011 special trigger resets timer, ADC
// R14: Modes 11xx waveform, bits 5-4 duty LSbs
// R15: Control bits 7-6 read zero; reset zero
// R16: Prescaler cleared when off or not capturing
// R17: Compare value continuously against timer
// R18: Control write of zero clears output latch
// R19: Special trigger reset never sets overflow flag
// R20: Pin passes two-flop synchroniser first
// R21: Event flag leaves as one-cycle set pulse
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.vh"

module ccu_unit #(
  parameter TIMER_W = 16
) (
  input  wire               clk,
  input  wire               sys_rst,
  input  wire               ctrlWr,
  input  wire               lowWr,
  input  wire               highWr,
  input  wire [7:0]         wrData,
  input  wire               pinIn,
  input  wire [TIMER_W-1:0] timerCount,
  output reg  [5:0]         ctrl_r,
  output reg  [TIMER_W-1:0] value_r,
  output reg                cmpOut_r,
  output reg                eventPulse_r,
  output reg                special_r,
  output reg                waveEnable_r,
  output reg  [9:0]         waveDuty_r
);

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  reg       pinMeta_r;
  reg       pinSync_r;
  reg       pinLast_r;
  reg [3:0] preCnt_r;
  reg [3:0] preCnt_nxt;
  reg       matchLast_r;
  reg       capture;
  reg       hit;

  wire [3:0] mode     = ctrl_r[`CCU_MODE_MSB:`CCU_MODE_LSB];
  wire       isCap    = (mode[3:2] == 2'b01);
  wire       isCmp    = (mode[3:2] == 2'b10);
  wire       rise     = pinSync_r & ~pinLast_r;
  wire       fall     = ~pinSync_r & pinLast_r;
  wire       match    = isCmp && (timerCount == value_r); // R17
  wire       cmpFire  = match & ~matchLast_r;

  // Pin level is taken as-is, so a port write while driven out still captures
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
      pinLast_r <= 1'b0;
    end else begin
      pinMeta_r <= pinIn; // R20 R09
      pinSync_r <= pinMeta_r; // R20
      pinLast_r <= pinSync_r;
    end
  end

  // ****************************************
  // Capture qualification
  // ****************************************
  always @* begin
    preCnt_nxt = preCnt_r;
    capture    = 1'b0;
    hit        = 1'b0;
    if (!isCap) begin
      preCnt_nxt = `CCU_PS_RESET; // R16 R03
    end else begin
      if (rise) begin
        preCnt_nxt = preCnt_r + 4'h1; // R16
      end
      case (mode)
        `CCU_MODE_CAP_FALL: begin
          capture = fall; // R04
        end
        `CCU_MODE_CAP_RISE: begin
          capture = rise; // R04
        end
        `CCU_MODE_CAP_4: begin
          hit     = ((preCnt_r & `CCU_PS_MASK4) == `CCU_PS_LAST4);
          capture = rise & hit; // R05
        end
        `CCU_MODE_CAP_16: begin
          hit     = (preCnt_r == `CCU_PS_LAST16);
          capture = rise & hit; // R05
        end
        default: begin
          capture = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Control, value, compare latch
  // ****************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r       <= `CCU_CTRL_RESET; // R15
      value_r      <= `CCU_VAL_RESET;
      cmpOut_r     <= 1'b0;
      eventPulse_r <= 1'b0;
      special_r    <= 1'b0;
      preCnt_r     <= `CCU_PS_RESET; // R16
      matchLast_r  <= 1'b0;
      waveEnable_r <= 1'b0;
      waveDuty_r   <= 10'h000;
    end else begin
      preCnt_r    <= preCnt_nxt;
      matchLast_r <= match;
      if (ctrlWr) begin
        ctrl_r <= wrData[`CCU_CTRL_W-1:0]; // R15
      end
      // Capture wins over a same-cycle software byte write
      if (capture) begin
        value_r <= timerCount; // R06 R08
      end else begin
        if (lowWr) begin
          value_r[7:0] <= wrData; // R01
        end
        if (highWr) begin
          value_r[TIMER_W-1:8] <= wrData; // R01
        end
      end
      eventPulse_r <= capture | cmpFire; // R07 R21 R10 R11 R12 R13
      special_r    <= cmpFire && (mode == `CCU_MODE_CMP_SPEC); // R13
      if (ctrlWr && (wrData[`CCU_CTRL_W-1:0] == `CCU_CTRL_RESET)) begin
        cmpOut_r <= 1'b0; // R18 R03
      end else if (cmpFire && (mode == `CCU_MODE_CMP_SET)) begin
        cmpOut_r <= 1'b1; // R10
      end else if (cmpFire && (mode == `CCU_MODE_CMP_CLR)) begin
        cmpOut_r <= 1'b0; // R11
      end
      // Period/duty timing lives with the waveform timer, not here
      waveEnable_r <= (mode[3:2] == 2'b11); // R14
      waveDuty_r   <= {value_r[7:0], ctrl_r[`CCU_DUTY_MSB:`CCU_DUTY_LSB]}; // R14
    end
  end

endmodule // ccu_unit

module ccu_top #(
  parameter TIMER_W = 16
) (
  input  wire               clk,
  input  wire               sys_rst,
  input  wire [7:0]         regAddr,
  input  wire [7:0]         regWrData,
  input  wire               regWr,
  input  wire               regRd,
  output reg  [7:0]         regRdData,
  input  wire [TIMER_W-1:0] timerCount,
  input  wire               unit1PinIn,
  input  wire               unit2PinIn,
  input  wire               adcEnabled,
  output wire               unit1CmpOut,
  output wire               unit2CmpOut,
  output wire               unit1EventSet,
  output wire               unit2EventSet,
  output reg                timerResetPulse,
  output reg                overflowSuppress,
  output reg                adcStartPulse,
  output wire               unit1WaveEnable,
  output wire               unit2WaveEnable,
  output wire [9:0]         unit1WaveDuty,
  output wire [9:0]         unit2WaveDuty
);

  // ****************************************
  // Register decode
  // ****************************************
  wire [5:0]         ctrl1;
  wire [5:0]         ctrl2;
  wire [TIMER_W-1:0] value1;
  wire [TIMER_W-1:0] value2;
  wire               special1;
  wire               special2;
  reg  [7:0]         rdNxt;

  wire wrU1Low  = regWr && (regAddr == `CCU_ADDR_U1_LOW);
  wire wrU1High = regWr && (regAddr == `CCU_ADDR_U1_HIGH);
  wire wrU1Ctrl = regWr && (regAddr == `CCU_ADDR_U1_CTRL);
  wire wrU2Low  = regWr && (regAddr == `CCU_ADDR_U2_LOW);
  wire wrU2High = regWr && (regAddr == `CCU_ADDR_U2_HIGH);
  wire wrU2Ctrl = regWr && (regAddr == `CCU_ADDR_U2_CTRL);

  always @* begin
    case (regAddr)
      `CCU_ADDR_U1_LOW:  rdNxt = value1[7:0];
      `CCU_ADDR_U1_HIGH: rdNxt = value1[TIMER_W-1:8];
      `CCU_ADDR_U1_CTRL: rdNxt = {2'b00, ctrl1}; // R15
      `CCU_ADDR_U2_LOW:  rdNxt = value2[7:0];
      `CCU_ADDR_U2_HIGH: rdNxt = value2[TIMER_W-1:8];
      `CCU_ADDR_U2_CTRL: rdNxt = {2'b00, ctrl2}; // R15
      default:           rdNxt = `CCU_RD_ZERO;
    endcase
  end

  // ****************************************
  // Units
  // ****************************************
  // Same module for both keeps them identical; only trigger use differs
  ccu_unit #(.TIMER_W(TIMER_W)) unitOne ( // R02
    .clk          (clk),
    .sys_rst      (sys_rst),
    .ctrlWr       (wrU1Ctrl),
    .lowWr        (wrU1Low),
    .highWr       (wrU1High),
    .wrData       (regWrData),
    .pinIn        (unit1PinIn),
    .timerCount   (timerCount),
    .ctrl_r       (ctrl1),
    .value_r      (value1),
    .cmpOut_r     (unit1CmpOut),
    .eventPulse_r (unit1EventSet),
    .special_r    (special1),
    .waveEnable_r (unit1WaveEnable),
    .waveDuty_r   (unit1WaveDuty)
  );

  ccu_unit #(.TIMER_W(TIMER_W)) unitTwo ( // R02
    .clk          (clk),
    .sys_rst      (sys_rst),
    .ctrlWr       (wrU2Ctrl),
    .lowWr        (wrU2Low),
    .highWr       (wrU2High),
    .wrData       (regWrData),
    .pinIn        (unit2PinIn),
    .timerCount   (timerCount),
    .ctrl_r       (ctrl2),
    .value_r      (value2),
    .cmpOut_r     (unit2CmpOut),
    .eventPulse_r (unit2EventSet),
    .special_r    (special2),
    .waveEnable_r (unit2WaveEnable),
    .waveDuty_r   (unit2WaveDuty)
  );

  // ****************************************
  // Read data and special triggers
  // ****************************************
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData        <= `CCU_RD_ZERO;
      timerResetPulse  <= 1'b0;
      overflowSuppress <= 1'b0;
      adcStartPulse    <= 1'b0;
    end else begin
      regRdData        <= regRd ? rdNxt : `CCU_RD_ZERO;
      timerResetPulse  <= special1 | special2; // R13
      overflowSuppress <= special1 | special2; // R19
      adcStartPulse    <= special2 & adcEnabled; // R13
    end
  end

endmodule // ccu_top
`default_nettype wire

// ---- ccu_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin source
// ****
module ccu_pin_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] pulses,
  input  wire logic [1:0] hold,
  output var  logic       pin,
  output var  logic       busy
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Levels held two cycles or more, else the synchroniser may drop one
  always @(posedge clk) begin
    if (go) begin
      busy <= 1'b1;
      repeat (pulses) begin
        repeat (hold) @(posedge clk);
        pin <= 1'b1;
        repeat (hold) @(posedge clk);
        pin <= 1'b0;
      end
      busy <= 1'b0;
    end
  end
endmodule // ccu_pin_model
`default_nettype wire

// ---- ccu_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.vh"
// ****
// Port checker
// ****
module ccu_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       adcEnabled,
  input wire logic       unit1CmpOut,
  input wire logic       unit1EventSet,
  input wire logic       unit2EventSet,
  input wire logic       timerResetPulse,
  input wire logic       overflowSuppress,
  input wire logic       adcStartPulse
);
  logic [3:0] mode1_r;
  logic [3:0] mode2_r;
  // Mode copied from bus writes, no mode port exists
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode1_r <= 4'h0;
      mode2_r <= 4'h0;
    end else if (regWr) begin
      if (regAddr == `CCU_ADDR_U1_CTRL) mode1_r <= regWrData[3:0];
      if (regAddr == `CCU_ADDR_U2_CTRL) mode2_r <= regWrData[3:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rdIdle; !$past(regRd) |-> regRdData == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
  property p_ovf; timerResetPulse |-> overflowSuppress; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not held off");
  property p_evt; unit1EventSet |=> !unit1EventSet; endproperty
  a_evt: assert property (p_evt) else $error("event pulse too long");
  property p_set; unit1EventSet && mode1_r == 4'h8 |-> unit1CmpOut; endproperty
  a_set: assert property (p_set) else $error("output not set");
  property p_clr; unit1EventSet && mode1_r == 4'h9 |-> !unit1CmpOut; endproperty
  a_clr: assert property (p_clr) else $error("output not cleared");
  property p_keep; mode1_r[3:1] == 3'b101 && $past(mode1_r[3:1]) == 3'b101 |-> $stable(unit1CmpOut); endproperty
  a_keep: assert property (p_keep) else $error("output moved");
  property p_spec; unit2EventSet && mode2_r == 4'hb && adcEnabled |=> adcStartPulse && timerResetPulse; endproperty
  a_spec: assert property (p_spec) else $error("no special trigger");
  property p_zero; regWr && regAddr == `CCU_ADDR_U1_CTRL && regWrData[5:0] == 6'h00 |=> !unit1CmpOut; endproperty
  a_zero: assert property (p_zero) else $error("output not reset");
  c_spec: cover property (adcStartPulse);
  c_cap: cover property (unit1EventSet && mode1_r[3:2] == 2'b01);
  c_set: cover property (unit1EventSet && unit1CmpOut);
endmodule // ccu_chk
`default_nettype wire

// ---- test_ccu_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ccu_defines.vh"
// ****
// Bench
// ****
module test_ccu_top;
  logic        clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, adcEnabled = 1'b0, run = 1'b0, go = 1'b0;
  logic [7:0]  regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [15:0] timerCount = 16'h0000, v;
  logic [4:0]  pulses = 5'h00;
  logic [1:0]  hold = 2'h2;
  logic [31:0] seed = 32'h51bb8595;
  logic        pin1, busy, unit1CmpOut, unit1EventSet, unit2EventSet, timerResetPulse, overflowSuppress, adcStartPulse;
  logic        wave1;
  logic [9:0]  duty1;
  int          errors = 0, comparisons = 0, ev1 = 0, adcN = 0;
  logic [3:0]  capM [4] = '{4'h5, 4'h4, 4'h6, 4'h7};
  int          capN [4] = '{3, 3, 9, 17};
  logic [3:0]  cmpM [4] = '{4'h9, 4'h8, 4'ha, 4'hb};
  logic        cmpQ [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  ccu_top ccu_top_i (.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .timerCount,
    .unit1PinIn(pin1), .unit2PinIn(1'b0), .adcEnabled, .unit1CmpOut, .unit2CmpOut(), .unit1EventSet,
    .unit2EventSet, .timerResetPulse, .overflowSuppress, .adcStartPulse, .unit1WaveEnable(wave1),
    .unit2WaveEnable(), .unit1WaveDuty(duty1), .unit2WaveDuty());
  ccu_pin_model ccu_pin_model_i (.clk, .go, .pulses, .hold, .pin(pin1), .busy);
  always #12.5 clk = ~clk;
  // Timer follows the special trigger like the real shared counter
  always @(posedge clk) begin
    if (run) timerCount <= timerResetPulse ? 16'h0000 : timerCount + 16'h0001;
    if (unit1EventSet === 1'b1) ev1++;
    if (adcStartPulse === 1'b1) adcN++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic int expEv(input logic [3:0] m, input int n);
    return m == 4'h6 ? n / 4 : m == 4'h7 ? n / 16 : n;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask
  task automatic burst(input int n);
    seed = xs(seed);
    @(posedge clk);
    pulses <= n[4:0];
    hold <= 2'h2 + {1'b0, seed[0]};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 400 && busy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic runTimer(input logic [15:0] s);
    @(posedge clk);
    timerCount <= s;
    run <= 1'b1;
    repeat (40) @(posedge clk);
    run <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`CCU_ADDR_U1_CTRL, 8'h00);
    wr(`CCU_ADDR_U1_CTRL, 8'hff);
    rd(`CCU_ADDR_U1_CTRL, 8'h3f);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    for (int u = 0; u < 2; u++) begin
      seed = xs(seed);
      wr(u ? `CCU_ADDR_U2_LOW : `CCU_ADDR_U1_LOW, seed[7:0]);
      wr(u ? `CCU_ADDR_U2_HIGH : `CCU_ADDR_U1_HIGH, seed[15:8]);
      rd(u ? `CCU_ADDR_U2_LOW : `CCU_ADDR_U1_LOW, seed[7:0]);
      rd(u ? `CCU_ADDR_U2_HIGH : `CCU_ADDR_U1_HIGH, seed[15:8]);
    end
    $display("registers done");
    for (int k = 0; k < 4; k++) begin
      wr(`CCU_ADDR_U1_CTRL, 8'h00);
      wr(`CCU_ADDR_U1_CTRL, {4'h0, capM[k]});
      seed = xs(seed);
      v = seed[15:0];
      timerCount <= v;
      ev1 = 0;
      burst(capN[k]);
      chk(ev1, expEv(capM[k], capN[k]));
      rd(`CCU_ADDR_U1_LOW, v[7:0]);
      rd(`CCU_ADDR_U1_HIGH, v[15:8]);
    end
    $display("capture done");
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = {1'b0, seed[14:0]} + 16'h0100;
      wr(`CCU_ADDR_U1_LOW, v[7:0]);
      wr(`CCU_ADDR_U1_HIGH, v[15:8]);
      wr(`CCU_ADDR_U1_CTRL, {4'h0, cmpM[k]});
      ev1 = 0;
      runTimer(v - 16'h0014);
      chk(ev1, 1);
      chk(unit1CmpOut, cmpQ[k]);
    end
    wr(`CCU_ADDR_U1_LOW, 8'ha5);
    wr(`CCU_ADDR_U1_CTRL, 8'h3c);
    repeat (2) @(posedge clk);
    #1;
    chk(wave1, 1'b1);
    chk(duty1, {8'ha5, 2'b11});
    chk(unit1CmpOut, 1'b1);
    wr(`CCU_ADDR_U1_CTRL, 8'h00);
    @(posedge clk);
    #1;
    chk(unit1CmpOut, 1'b0);
    chk(wave1, 1'b0);
    adcEnabled <= 1'b1;
    wr(`CCU_ADDR_U2_LOW, 8'h40);
    wr(`CCU_ADDR_U2_HIGH, 8'h02);
    wr(`CCU_ADDR_U2_CTRL, 8'h0b);
    adcN = 0;
    runTimer(16'h022c);
    chk(adcN, 1);
    $display("compare done");
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    wrap_up;
  end
endmodule // test_ccu_top
bind ccu_top ccu_chk ccu_chk_i (.clk, .sys_rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .adcEnabled,
  .unit1CmpOut, .unit1EventSet, .unit2EventSet, .timerResetPulse, .overflowSuppress, .adcStartPulse);
`default_nettype wire
